/* logic/fdcv_verify_cfg.sv */
`include "fdcv_regs.svh"
module fdcv_verify_cfg (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic sw_reset_in,
   input wire logic bus_reset_input_in,
   input wire logic cmd_valid_in,
   input wire fdcv_pkg::fdcv_byte_t cmd_byte_in,
   output logic cmd_ready_out,
   output logic res_valid_out,
   output fdcv_pkg::fdcv_byte_t res_byte_out,
   input wire logic res_ack_in,
   input wire logic disk_valid_in,
   input wire fdcv_pkg::fdcv_byte_t disk_byte_in,
   input wire logic disk_mark_in,
   input wire logic index_in,
   input wire logic drive_ready_in,
   input wire logic perp_cmd_in,
   input wire logic fm_rate_wr_in,
   input wire logic [1:0] fm_rate_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_implied_seek_in,
   input wire logic cfg_fifo_disable_in,
   input wire logic cfg_scan_off_in,
   input wire logic [3:0] cfg_threshold_in,
   input wire fdcv_pkg::fdcv_byte_t cfg_precomp_in,
   output logic implied_seek_enable_out,
   output logic fifo_disable_out,
   output logic auto_drive_scan_off_out,
   output logic [3:0] fifo_threshold_out,
   output fdcv_pkg::fdcv_byte_t precomp_start_track_out,
   output logic fifo_settings_freeze_out,
   output logic [2:0] power_opt_out,
   output logic perp_mode_out,
   output logic mfm_mode_out,
   output logic [1:0] fm_rate_out,
   output logic head_load_out,
   output logic verify_busy_out,
   output logic [1:0] drive_sel_out
);
   import fdcv_pkg::*;

   // pins: [0] index, [1] drive ready, [2] bus reset
   logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
   logic idx_prev_q, idx_rise;
   always_comb begin
      lvl_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
      idx_rise = lvl_q[0] & ~idx_prev_q;
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         lvl_q <= 3'h0;
         idx_prev_q <= 1'b0;
      end else begin
         s1_q <= {bus_reset_input_in, drive_ready_in, index_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         idx_prev_q <= lvl_q[0];
      end
   end

   // configuration and persistent command state
   logic set_ver, set_lock, set_pwr;
   logic [7:0] rev_q, rev_d, ptn_q, ptn_d;
   logic lock_q, lock_d, eis_q, eis_d, dfi_q, dfi_d, pol_q, pol_d, perp_q, perp_d;
   logic [3:0] fth_q, fth_d;
   logic [2:0] pwr_q, pwr_d;
   logic [1:0] rate_q, rate_d;
   always_comb begin
      rev_d = set_ver ? cmd_byte_in : rev_q;
      lock_d = set_lock ? cmd_byte_in[`FDCV_LOCK_CMD_BIT] : lock_q;
      pwr_d = set_pwr ? cmd_byte_in[2:0] : pwr_q;
      perp_d = perp_q | perp_cmd_in;
      rate_d = rate_q;
      if (fm_rate_wr_in && (fm_rate_in == `FDCV_RATE_125 || fm_rate_in == `FDCV_RATE_150
            || fm_rate_in == `FDCV_RATE_250)) begin
         rate_d = fm_rate_in;
      end
      eis_d = cfg_wr_in ? cfg_implied_seek_in : eis_q;
      dfi_d = cfg_wr_in ? cfg_fifo_disable_in : dfi_q;
      pol_d = cfg_wr_in ? cfg_scan_off_in : pol_q;
      fth_d = cfg_wr_in ? cfg_threshold_in : fth_q;
      ptn_d = cfg_wr_in ? cfg_precomp_in : ptn_q;
      // soft reset leaves revision and power options alone
      if (sw_reset_in) begin
         eis_d = 1'b0;
         pol_d = 1'b0;
         if (!lock_q) begin
            dfi_d = `FDCV_DFI_HW;
            fth_d = `FDCV_FTH_HW;
            ptn_d = `FDCV_PTN_HW;
         end
      end
      if (lvl_q[2]) begin
         pwr_d = 3'h0;
      end
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rev_q <= `FDCV_VER_HW;
         lock_q <= 1'b0;
         eis_q <= 1'b0;
         dfi_q <= `FDCV_DFI_HW;
         pol_q <= 1'b0;
         fth_q <= `FDCV_FTH_HW;
         ptn_q <= `FDCV_PTN_HW;
         pwr_q <= 3'h0;
         perp_q <= 1'b0;
         rate_q <= `FDCV_RATE_250;
      end else begin
         rev_q <= rev_d;
         lock_q <= lock_d;
         eis_q <= eis_d;
         dfi_q <= dfi_d;
         pol_q <= pol_d;
         fth_q <= fth_d;
         ptn_q <= ptn_d;
         pwr_q <= pwr_d;
         perp_q <= perp_d;
         rate_q <= rate_d;
      end
   end

   // command sequencer; cb holds cmd1, cmd2, c, h, r, n, eot, gsl, dtl
   fdcv_state_t st_q, st_d;
   logic [7:0] cb_q [0:8];
   logic [7:0] cb_d [0:8];
   logic [7:0] res_q [0:6];
   logic [7:0] res_d [0:6];
   logic [7:0] sec_q, sec_d, st0_q, st0_d, st1_q, st1_d, st2_q, st2_d, rb_q, rb_d;
   logic [3:0] pcnt_q, pcnt_d, need_q, need_d;
   logic [2:0] rcnt_q, rcnt_d, ridx_q, ridx_d, zrun_q, zrun_d;
   logic [14:0] tmr_q, tmr_d, bcnt_q, bcnt_d, dlast;
   logic [1:0] icnt_q, icnt_d;
   logic idseen_q, idseen_d, idbad_q, idbad_d, fld_q, fld_d, hl_q, hl_d, mfm_q, mfm_d;
   logic rdy_q, rdy_d, rv_q, rv_d, bsy_q, bsy_d, finish, mark_ok, crc_clr, crc_vld;
   logic [15:0] crc;

   fdcv_crc16 u_crc (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .clear_in(crc_clr),
      .valid_in(crc_vld),
      .byte_in(disk_byte_in),
      .crc_out(crc)
   );

   always_comb begin
      st_d = st_q;
      cb_d = cb_q;
      res_d = res_q;
      sec_d = sec_q;
      st0_d = st0_q;
      st1_d = st1_q;
      st2_d = st2_q;
      pcnt_d = pcnt_q;
      need_d = need_q;
      rcnt_d = rcnt_q;
      ridx_d = ridx_q;
      zrun_d = zrun_q;
      tmr_d = tmr_q;
      bcnt_d = bcnt_q;
      icnt_d = icnt_q;
      idseen_d = idseen_q;
      idbad_d = idbad_q;
      fld_d = fld_q;
      hl_d = hl_q;
      mfm_d = mfm_q;
      set_ver = 1'b0;
      set_lock = 1'b0;
      set_pwr = 1'b0;
      finish = 1'b0;
      dlast = 15'(`FDCV_SEC_BASE << cb_q[5][2:0]) + `FDCV_CRC_LEN - 15'h0001;
      // a mark counts only after a full run of zero sync bytes
      mark_ok = disk_valid_in & disk_mark_in & (zrun_q >= `FDCV_FM_SYNC_LEN);
      crc_clr = (st_q == S_FIND_ID) || (st_q == S_FIND_DAT);
      crc_vld = disk_valid_in & (crc_clr ? mark_ok : (st_q == S_ID || st_q == S_DATA));
      if (crc_clr && disk_valid_in) begin
         zrun_d = (disk_byte_in == 8'h00 && !disk_mark_in)
            ? ((zrun_q == `FDCV_FM_SYNC_LEN) ? zrun_q : zrun_q + 3'h1) : 3'h0;
      end
      unique case (st_q)
         S_IDLE: begin
            if (cmd_valid_in) begin
               cb_d[0] = cmd_byte_in;
               pcnt_d = 4'h1;
               ridx_d = 3'h0;
               rcnt_d = 3'h1;
               if (cmd_byte_in[4:0] == `FDCV_OP_VERIFY) begin
                  need_d = `FDCV_NPAR_VERIFY;
                  mfm_d = cmd_byte_in[6];
                  st_d = S_PARAM;
               end else if (cmd_byte_in == `FDCV_OP_SET_CHIP_REVISION_CMD || cmd_byte_in == `FDCV_OP_PWRDN) begin
                  need_d = `FDCV_NPAR_ONE;
                  st_d = S_PARAM;
               end else if (cmd_byte_in == `FDCV_OP_VERSION) begin
                  res_d[0] = rev_q;
                  st_d = S_RESULT;
               end else if (cmd_byte_in[6:0] == `FDCV_OP_LOCK) begin
                  set_lock = 1'b1;
                  res_d[0] = 8'h00;
                  res_d[0][`FDCV_LOCK_RES_BIT] = cmd_byte_in[`FDCV_LOCK_CMD_BIT];
                  st_d = S_RESULT;
               end
            end
         end
         S_PARAM: begin
            if (cmd_valid_in) begin
               cb_d[pcnt_q] = cmd_byte_in;
               pcnt_d = pcnt_q + 4'h1;
               if (pcnt_q == need_q) begin
                  if (cb_q[0] == `FDCV_OP_SET_CHIP_REVISION_CMD) begin
                     set_ver = 1'b1;
                     st_d = S_IDLE;
                  end else if (cb_q[0] == `FDCV_OP_PWRDN) begin
                     set_pwr = 1'b1;
                     res_d[0] = {5'h00, cmd_byte_in[2:0]};
                     st_d = S_RESULT;
                  end else begin
                     sec_d = cb_q[4];
                     st0_d = {5'h00, cb_q[1][2:0]};
                     st1_d = 8'h00;
                     st2_d = 8'h00;
                     tmr_d = `FDCV_HEADLD_CYC;
                     st_d = S_HEADLD;
                  end
               end
            end
         end
         S_HEADLD: begin
            hl_d = 1'b1;
            if (!lvl_q[1]) begin
               st0_d[`FDCV_ST0_IC] = 1'b1;
               st0_d[`FDCV_ST0_NR] = 1'b1;
               finish = 1'b1;
            end else if (tmr_q == 15'h0000) begin
               icnt_d = 2'h0;
               idseen_d = 1'b0;
               zrun_d = 3'h0;
               st_d = S_FIND_ID;
            end else begin
               tmr_d = tmr_q - 15'h0001;
            end
         end
         S_FIND_ID: begin
            if (idx_rise) begin
               icnt_d = icnt_q + 2'h1;
               if (icnt_d == `FDCV_IDX_LIMIT) begin
                  if (idseen_q) begin
                     st1_d[`FDCV_ST1_ND] = 1'b1;
                  end else begin
                     st0_d[`FDCV_ST0_IC] = 1'b1;
                     st1_d[`FDCV_ST1_MA] = 1'b1;
                  end
                  st_d = S_NEXT;
               end
            end else if (mark_ok && disk_byte_in == `FDCV_FM_ID) begin
               idseen_d = 1'b1;
               idbad_d = 1'b0;
               bcnt_d = 15'h0000;
               st_d = S_ID;
            end
         end
         S_ID: begin
            if (disk_valid_in) begin
               bcnt_d = bcnt_q + 15'h0001;
               unique case (bcnt_q[2:0])
                  3'h0: idbad_d = idbad_q | (disk_byte_in != cb_q[2] && disk_byte_in != `FDCV_CYL_ANY);
                  3'h1: idbad_d = idbad_q | (disk_byte_in != cb_q[3]);
                  3'h2: idbad_d = idbad_q | (disk_byte_in != sec_q);
                  3'h3: idbad_d = idbad_q | (disk_byte_in != cb_q[5]);
                  default: idbad_d = idbad_q;
               endcase
               if (bcnt_q == `FDCV_ID_LAST) begin
                  fld_d = 1'b0;
                  st_d = S_CHK;
               end
            end
         end
         S_CHK: begin
            zrun_d = 3'h0;
            if (fld_q) begin
               if (crc != 16'h0000) begin
                  st1_d[`FDCV_ST1_DE] = 1'b1;
                  st2_d[`FDCV_ST2_DD] = 1'b1;
               end
               st_d = S_NEXT;
            end else if (idbad_q) begin
               st_d = S_FIND_ID;
            end else if (crc != 16'h0000) begin
               st1_d[`FDCV_ST1_DE] = 1'b1;
               st_d = S_NEXT;
            end else begin
               st_d = S_FIND_DAT;
            end
         end
         S_FIND_DAT: begin
            if (idx_rise || (mark_ok && disk_byte_in == `FDCV_FM_ID)) begin
               st0_d[`FDCV_ST0_IC] = 1'b1;
               st1_d[`FDCV_ST1_MA] = 1'b1;
               st2_d[`FDCV_ST2_MD] = 1'b1;
               st_d = S_NEXT;
            end else if (mark_ok && (disk_byte_in == `FDCV_FM_DAT || disk_byte_in == `FDCV_FM_DEL)) begin
               st2_d[`FDCV_ST2_CM] = st2_q[`FDCV_ST2_CM] | (disk_byte_in == `FDCV_FM_DEL);
               bcnt_d = 15'h0000;
               st_d = S_DATA;
            end
         end
         S_DATA: begin
            // data is only counted and checked, never handed to the host
            if (idx_rise) begin
               st0_d[`FDCV_ST0_IC] = 1'b1;
               st1_d[`FDCV_ST1_EN] = 1'b1;
               st_d = S_NEXT;
            end else if (disk_valid_in) begin
               bcnt_d = bcnt_q + 15'h0001;
               if (bcnt_q == dlast) begin
                  fld_d = 1'b1;
                  st_d = S_CHK;
               end
            end
         end
         S_NEXT: begin
            sec_d = sec_q + 8'h01;
            if (sec_q == cb_q[6]) begin
               finish = 1'b1;
            end else begin
               icnt_d = 2'h0;
               idseen_d = 1'b0;
               zrun_d = 3'h0;
               st_d = S_FIND_ID;
            end
         end
         S_RESULT: begin
            if (res_ack_in) begin
               if (ridx_q == rcnt_q - 3'h1) begin
                  st_d = S_IDLE;
               end else begin
                  ridx_d = ridx_q + 3'h1;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (finish) begin
         // flags accumulate over all sectors, so the failing sector is lost
         res_d[0] = st0_d;
         res_d[1] = st1_d;
         res_d[2] = st2_d;
         res_d[3] = cb_q[2];
         res_d[4] = cb_q[3];
         res_d[5] = sec_d;
         res_d[6] = cb_q[5];
         rcnt_d = `FDCV_VERIFY_RES;
         ridx_d = 3'h0;
         hl_d = 1'b0;
         st_d = S_RESULT;
      end
      if (sw_reset_in) begin
         hl_d = 1'b0;
         st_d = S_IDLE;
      end
      rdy_d = (st_d == S_IDLE) || (st_d == S_PARAM);
      rv_d = (st_d == S_RESULT);
      bsy_d = !rdy_d && !rv_d;
      rb_d = res_d[ridx_d];
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= S_IDLE;
         for (int i = 0; i < 9; i++) begin
            cb_q[i] <= 8'h00;
         end
         for (int i = 0; i < 7; i++) begin
            res_q[i] <= 8'h00;
         end
         sec_q <= 8'h00;
         st0_q <= 8'h00;
         st1_q <= 8'h00;
         st2_q <= 8'h00;
         rb_q <= 8'h00;
         pcnt_q <= 4'h0;
         need_q <= 4'h0;
         rcnt_q <= 3'h0;
         ridx_q <= 3'h0;
         zrun_q <= 3'h0;
         tmr_q <= 15'h0000;
         bcnt_q <= 15'h0000;
         icnt_q <= 2'h0;
         {idseen_q, idbad_q, fld_q, hl_q, mfm_q, rv_q, bsy_q} <= 7'h00;
         rdy_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cb_q <= cb_d;
         res_q <= res_d;
         sec_q <= sec_d;
         st0_q <= st0_d;
         st1_q <= st1_d;
         st2_q <= st2_d;
         rb_q <= rb_d;
         pcnt_q <= pcnt_d;
         need_q <= need_d;
         rcnt_q <= rcnt_d;
         ridx_q <= ridx_d;
         zrun_q <= zrun_d;
         tmr_q <= tmr_d;
         bcnt_q <= bcnt_d;
         icnt_q <= icnt_d;
         {idseen_q, idbad_q, fld_q, hl_q, mfm_q, rv_q, bsy_q} <= {idseen_d, idbad_d, fld_d, hl_d, mfm_d, rv_d, bsy_d};
         rdy_q <= rdy_d;
      end
   end

   assign cmd_ready_out = rdy_q;
   assign res_valid_out = rv_q;
   assign res_byte_out = rb_q;
   assign implied_seek_enable_out = eis_q;
   assign fifo_disable_out = dfi_q;
   assign auto_drive_scan_off_out = pol_q;
   assign fifo_threshold_out = fth_q;
   assign precomp_start_track_out = ptn_q;
   assign fifo_settings_freeze_out = lock_q;
   assign power_opt_out = pwr_q;
   assign perp_mode_out = perp_q;
   assign mfm_mode_out = mfm_q;
   assign fm_rate_out = rate_q;
   assign head_load_out = hl_q;
   assign verify_busy_out = bsy_q;
   assign drive_sel_out = cb_q[1][1:0];

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_lock_cmd;
      st_q == S_IDLE && cmd_valid_in && cmd_byte_in[6:0] == `FDCV_OP_LOCK;
   endsequence
   sequence s_lock_answer(logic b);
      res_valid_out && res_byte_out == {3'h0, b, 4'h0};
   endsequence

   rev_soft_keep_a: assert property (sw_reset_in && !set_ver |=> rev_q == $past(rev_q))
      else $error("revision changed by software reset");
   lock_keep_a: assert property (sw_reset_in && lock_q && !cfg_wr_in
         |=> dfi_q == $past(dfi_q) && fth_q == $past(fth_q) && ptn_q == $past(ptn_q))
      else $error("locked fifo settings lost on software reset");
   unlock_clear_a: assert property (sw_reset_in && !lock_q
         |=> dfi_q && fth_q == 4'h0 && ptn_q == 8'h00 && !eis_q && !pol_q)
      else $error("software reset did not restore defaults");
   pwr_bus_a: assert property (lvl_q[2] |=> power_opt_out == 3'h0)
      else $error("bus reset did not clear power options");
   lock_answer_a: assert property (s_lock_cmd ##0 !sw_reset_in
         |=> s_lock_answer($past(cmd_byte_in[7])) ##0 fifo_settings_freeze_out == $past(cmd_byte_in[7]))
      else $error("lock answer wrong");
   set_chip_revision_cmd_a: assert property (set_ver |=> rev_q == $past(cmd_byte_in) && !res_valid_out)
      else $error("revision not stored");
   next_sector_a: assert property (st_q == S_NEXT && sec_q != cb_q[6] && !sw_reset_in
         |=> st_q == S_FIND_ID && sec_q == $past(sec_q) + 8'h01)
      else $error("verify ended early or sector not advanced");
   dat_miss_a: assert property (st_q == S_FIND_DAT && !idx_rise && mark_ok && disk_byte_in == `FDCV_FM_ID
         |=> st0_q[`FDCV_ST0_IC] && st1_q[`FDCV_ST1_MA] && st2_q[`FDCV_ST2_MD])
      else $error("missing data mark not flagged");
   not_ready_a: assert property (st_q == S_HEADLD && !lvl_q[1] && !sw_reset_in
         |=> res_valid_out ##0 res_byte_out[`FDCV_ST0_NR] && res_byte_out[`FDCV_ST0_IC])
      else $error("not ready not reported");
endmodule : fdcv_verify_cfg

/* logic/fdcv_regs.svh */
`ifndef FDCV_REGS_SVH
`define FDCV_REGS_SVH
`define FDCV_OP_VERIFY 5'h16
`define FDCV_OP_VERSION 8'h10
`define FDCV_OP_SET_CHIP_REVISION_CMD 8'h30
`define FDCV_OP_LOCK 7'h14
`define FDCV_OP_PWRDN 8'h17
`define FDCV_NPAR_VERIFY 4'h8
`define FDCV_NPAR_ONE 4'h1
`define FDCV_VER_HW 8'h90
`define FDCV_FM_IDX 8'hFC
`define FDCV_FM_ID 8'hFE
`define FDCV_FM_DAT 8'hFB
`define FDCV_FM_DEL 8'hF8
`define FDCV_MFM_IDX 8'hC2
`define FDCV_MFM_SYNC 8'hA1
`define FDCV_FM_SYNC_LEN 3'h6
`define FDCV_CYL_ANY 8'hFF
`define FDCV_CRC_INIT 16'hFFFF
`define FDCV_CRC_POLY 16'h1021
`define FDCV_CLK_NS 10
`define FDCV_HEADLD_NS 2000
`define FDCV_HEADLD_CYC 15'((`FDCV_HEADLD_NS + `FDCV_CLK_NS - 1) / `FDCV_CLK_NS)
`define FDCV_IDX_LIMIT 2'h2
`define FDCV_SEC_BASE 15'h0080
`define FDCV_ID_LAST 15'h0005
`define FDCV_CRC_LEN 15'h0002
`define FDCV_ST0_IC 6
`define FDCV_ST0_NR 3
`define FDCV_ST1_EN 7
`define FDCV_ST1_DE 5
`define FDCV_ST1_ND 2
`define FDCV_ST1_MA 0
`define FDCV_ST2_CM 6
`define FDCV_ST2_DD 5
`define FDCV_ST2_MD 0
`define FDCV_LOCK_CMD_BIT 7
`define FDCV_LOCK_RES_BIT 4
`define FDCV_DFI_HW 1'b1
`define FDCV_FTH_HW 4'h0
`define FDCV_PTN_HW 8'h00
`define FDCV_RATE_125 2'h0
`define FDCV_RATE_150 2'h1
`define FDCV_RATE_250 2'h2
`define FDCV_VERIFY_RES 3'h7
`endif

/* logic/fdcv_pkg.sv */
package fdcv_pkg;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_PARAM = 4'h1,
      S_HEADLD = 4'h2,
      S_FIND_ID = 4'h3,
      S_ID = 4'h4,
      S_FIND_DAT = 4'h5,
      S_DATA = 4'h6,
      S_CHK = 4'h7,
      S_NEXT = 4'h8,
      S_RESULT = 4'h9
   } fdcv_state_t;
   typedef logic [7:0] fdcv_byte_t;
endpackage : fdcv_pkg

/* logic/fdcv_crc16.sv */
`include "fdcv_regs.svh"
module fdcv_crc16 (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic clear_in,
   input wire logic valid_in,
   input wire fdcv_pkg::fdcv_byte_t byte_in,
   output logic [15:0] crc_out
);
   import fdcv_pkg::*;

   logic [15:0] crc_q, crc_d, base;

   // msb first, same order the byte leaves the head
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r = {r[14:0], 1'b0} ^ (fb ? `FDCV_CRC_POLY : 16'h0000);
      end
      return r;
   endfunction : crc_step

   always_comb begin
      base = clear_in ? `FDCV_CRC_INIT : crc_q;
      crc_d = valid_in ? crc_step(base, byte_in) : base;
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         crc_q <= `FDCV_CRC_INIT;
      end else begin
         crc_q <= crc_d;
      end
   end

   assign crc_out = crc_q;
endmodule : fdcv_crc16

/* sim/fdcv_disk_model.sv */
module fdcv_disk_model (
   input wire logic mclk_in,
   output logic disk_valid_out,
   output fdcv_pkg::fdcv_byte_t disk_byte_out,
   output logic disk_mark_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import fdcv_pkg::*;
   logic [15:0] crc_acc = 16'hffff;
   initial begin
      disk_valid_out = 1'b0;
      disk_byte_out = 8'h00;
      disk_mark_out = 1'b0;
   end
   // idle byte lines show the inverse so a stale value never looks valid
   task automatic put(input fdcv_byte_t b, input logic m);
      @(posedge mclk_in);
      disk_valid_out <= 1'b1;
      disk_byte_out <= b;
      disk_mark_out <= m;
      for (int i = 7; i >= 0; i--) begin
         crc_acc = {crc_acc[14:0], 1'b0} ^ ((crc_acc[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      end
      @(posedge mclk_in);
      disk_valid_out <= 1'b0;
      disk_byte_out <= ~b;
      disk_mark_out <= 1'b0;
   endtask : put
   task automatic field_end(input logic bad);
      logic [15:0] t;
      t = crc_acc ^ {15'h0000, bad};
      put(t[15:8], 1'b0);
      put(t[7:0], 1'b0);
   endtask : field_end
   task automatic sector(input fdcv_byte_t c, h, r, n, dm, input logic bad);
      repeat (6) put(8'h00, 1'b0);
      crc_acc = 16'hffff;
      put(8'hfe, 1'b1);
      put(c, 1'b0);
      put(h, 1'b0);
      put(r, 1'b0);
      put(n, 1'b0);
      field_end(1'b0);
      repeat (11) put(8'hff, 1'b0);
      repeat (6) put(8'h00, 1'b0);
      crc_acc = 16'hffff;
      put(dm, 1'b1);
      for (int i = 0; i < 128; i++) put(i[7:0], 1'b0);
      field_end(bad);
      put(8'hff, 1'b0);
   endtask : sector
endmodule : fdcv_disk_model

/* sim/test_fdcv_verify_cfg.sv */
module test_fdcv_verify_cfg;
   timeunit 1ns;
   timeprecision 1ns;
   import fdcv_pkg::*;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic sw_reset_in = 1'b0, bus_reset_input_in = 1'b0, cmd_valid_in = 1'b0, res_ack_in = 1'b0;
   logic drive_ready_in = 1'b0, perp_cmd_in = 1'b0, fm_rate_wr_in = 1'b0, cfg_wr_in = 1'b0;
   logic cfg_implied_seek_in = 1'b0, cfg_fifo_disable_in = 1'b0, cfg_scan_off_in = 1'b0;
   logic [3:0] cfg_threshold_in = 4'h0;
   logic [1:0] fm_rate_in = 2'h0;
   fdcv_byte_t cmd_byte_in = 8'h00, cfg_precomp_in = 8'h00;
   logic cmd_ready_out, res_valid_out, disk_valid_in, disk_mark_in, implied_seek_enable_out;
   logic fifo_disable_out, auto_drive_scan_off_out, fifo_settings_freeze_out, perp_mode_out;
   fdcv_byte_t res_byte_out, disk_byte_in, precomp_start_track_out;
   logic [3:0] fifo_threshold_out;
   logic [2:0] power_opt_out;
   logic [1:0] fm_rate_out, drive_sel_out;
   logic mfm_mode_out, head_load_out, verify_busy_out, index_in = 1'b0;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   fdcv_verify_cfg u_fdcv_verify_cfg (.mclk_in, .resetn_in, .sw_reset_in, .bus_reset_input_in, .cmd_valid_in,
      .cmd_byte_in, .cmd_ready_out, .res_valid_out, .res_byte_out, .res_ack_in, .disk_valid_in, .disk_byte_in,
      .disk_mark_in, .index_in, .drive_ready_in, .perp_cmd_in, .fm_rate_wr_in, .fm_rate_in, .cfg_wr_in,
      .cfg_implied_seek_in, .cfg_fifo_disable_in, .cfg_scan_off_in, .cfg_threshold_in, .cfg_precomp_in,
      .implied_seek_enable_out, .fifo_disable_out, .auto_drive_scan_off_out, .fifo_threshold_out,
      .precomp_start_track_out, .fifo_settings_freeze_out, .power_opt_out, .perp_mode_out, .mfm_mode_out,
      .fm_rate_out, .head_load_out, .verify_busy_out, .drive_sel_out);
   fdcv_disk_model u_fdcv_disk_model (.mclk_in, .disk_valid_out(disk_valid_in), .disk_byte_out(disk_byte_in),
      .disk_mark_out(disk_mark_in));
   always #5 mclk_in = ~mclk_in;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   // verify runs take up to about 1000 cycles each
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input fdcv_byte_t b);
      @(posedge mclk_in);
      cmd_valid_in <= 1'b1;
      cmd_byte_in <= b;
      do @(posedge mclk_in); while (cmd_ready_out !== 1'b1);
      cmd_valid_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] exp);
      do @(posedge mclk_in); while (res_valid_out !== 1'b1);
      chk(res_byte_out, exp);
      res_ack_in <= 1'b1;
      @(posedge mclk_in);
      res_ack_in <= 1'b0;
   endtask : rd
   task automatic swr();
      @(posedge mclk_in);
      sw_reset_in <= 1'b1;
      @(posedge mclk_in);
      sw_reset_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
   endtask : swr
   task automatic vfy(input fdcv_byte_t c1, eot, dm, input logic bad, input logic [7:0] s0, s1, s2, r);
      fdcv_byte_t cb[9];
      cb = '{c1, {5'h00, s0[2:0]}, 8'h01, 8'h00, 8'h01, 8'h00, eot, 8'h0a, 8'hff};
      foreach (cb[i]) wr(cb[i]);
      if (drive_ready_in) begin
         repeat (100) @(posedge mclk_in);
         chk({mfm_mode_out, drive_sel_out, verify_busy_out, head_load_out}, {c1[6], s0[1:0], 2'b11});
         repeat (160) @(posedge mclk_in);
         u_fdcv_disk_model.sector(8'h01, 8'h00, 8'h01, 8'h00, dm, bad);
         if (eot == 8'h03) begin
            // second sector has wildcard cylinder and no data mark, third sector never shows up
            u_fdcv_disk_model.sector(8'hff, 8'h00, 8'h02, 8'h00, 8'hfe, 1'b0);
            repeat (2) begin
               index_in <= 1'b1;
               repeat (4) @(posedge mclk_in);
               index_in <= 1'b0;
               repeat (4) @(posedge mclk_in);
            end
         end
      end
      rd(s0);
      rd(s1);
      rd(s2);
      rd(8'h01);
      rd(8'h00);
      rd(r);
      rd(8'h00);
      $display("test verify done");
   endtask : vfy
   initial begin
      repeat (16) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      chk(fifo_disable_out, 8'h01);
      chk(fifo_settings_freeze_out, 8'h00);
      chk(power_opt_out, 8'h00);
      chk(perp_mode_out, 8'h00);
      wr(8'h10);
      rd(8'h90);
      wr(8'h30);
      wr(8'h55);
      swr();
      wr(8'h10);
      rd(8'h55);
      $display("test revision done");
      cfg_wr_in <= 1'b1;
      cfg_implied_seek_in <= 1'b1;
      cfg_scan_off_in <= 1'b1;
      cfg_threshold_in <= 4'h5;
      cfg_precomp_in <= 8'h21;
      @(posedge mclk_in);
      cfg_wr_in <= 1'b0;
      wr(8'h94);
      rd(8'h10);
      chk(implied_seek_enable_out, 8'h01);
      swr();
      chk({fifo_disable_out, fifo_threshold_out}, 8'h05);
      chk(precomp_start_track_out, 8'h21);
      chk({implied_seek_enable_out, auto_drive_scan_off_out}, 8'h00);
      wr(8'h14);
      rd(8'h00);
      swr();
      chk({fifo_disable_out, fifo_threshold_out, precomp_start_track_out[2:0]}, 8'h80);
      $display("test lock done");
      wr(8'h17);
      wr(8'h05);
      rd(8'h05);
      swr();
      chk(power_opt_out, 8'h05);
      bus_reset_input_in <= 1'b1;
      repeat (8) @(posedge mclk_in);
      chk(power_opt_out, 8'h00);
      bus_reset_input_in <= 1'b0;
      fm_rate_wr_in <= 1'b1;
      @(posedge mclk_in);
      fm_rate_in <= 2'h3;
      perp_cmd_in <= 1'b1;
      @(posedge mclk_in);
      fm_rate_wr_in <= 1'b0;
      perp_cmd_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      chk({fm_rate_out, perp_mode_out}, 8'h01);
      $display("test power and mode done");
      vfy(8'h16, 8'h01, 8'hfb, 1'b0, 8'h49, 8'h00, 8'h00, 8'h01);
      drive_ready_in <= 1'b1;
      repeat (8) @(posedge mclk_in);
      vfy(8'h16, 8'h01, 8'hfb, 1'b0, 8'h00, 8'h00, 8'h00, 8'h02);
      vfy(8'h16, 8'h01, 8'hf8, 1'b1, 8'h00, 8'h20, 8'h60, 8'h02);
      vfy(8'h56, 8'h03, 8'hf8, 1'b1, 8'h42, 8'h21, 8'h61, 8'h04);
      report_and_stop();
   end
endmodule : test_fdcv_verify_cfg
